/* File: verilog/rss_sequencer.sv */
`timescale 1ns/100ps
module rss_sequencer #(
  parameter int DELAY_STEP_CYC = rss_pkg::DELAY_STEP_CYC,
  parameter int RAMP_NUM = rss_pkg::RAMP_NUM,
  parameter int PG_MASK_CYC = rss_pkg::PG_MASK_CYC,
  parameter logic [6:0] DEV_ADDR = rss_pkg::DEV_ADDR_RST
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic en_pin,
  input wire logic supply_undervoltage_lockout,
  input wire logic limit_over,
  input wire logic [7:0] target_voltage_code,
  input wire logic [3:0] pwm_req,
  input wire logic [3:1] phase_sense,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output rss_pkg::rss_pins_t phase_pins,
  output logic phase_sink_en,
  output logic [3:0] phase_tick,
  output logic [7:0] ref_code,
  output logic power_good,
  output logic limit_trip,
  output logic latched_off,
  output rss_pkg::rss_scale_t scales
);
  import rss_pkg::*;

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  logic en_s, supply_ok_s, trip_s;
  logic [7:0] tv_s;
  logic [3:1] pin_s;
  logic [1:0] bus_s;

  // lockout is synced inverted, so a freshly reset synchroniser never reads as supply ready
  rss_sync #(.W(14)) u_sync_pins (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .d({en_pin, ~supply_undervoltage_lockout, limit_over, target_voltage_code, phase_sense}),
    .q({en_s, supply_ok_s, trip_s, tv_s, pin_s})
  );

  rss_sync #(.W(2)) u_sync_bus (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .d({scl_in, sda_in}),
    .q(bus_s)
  );

  // ------------------------------------------------------------
  // settings registers
  // ------------------------------------------------------------
  logic [7:0] delay_sel_q, slew_sel_q, ilim_q, llcal_q, llset_q;
  logic [7:0] cmd_q, wdat_q, rd_data;
  logic wr_q;
  rss_seq_t st_q;
  logic [3:0] active_q;
  logic lat_busy_q;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      delay_sel_q <= DELAY_RST;
      slew_sel_q <= SLEW_RST;
      ilim_q <= ILIM_RST;
      llcal_q <= LL_RST;
      llset_q <= LL_RST;
    end else if (wr_q) begin
      unique case (cmd_q)
        CMD_DELAY: delay_sel_q <= wdat_q;
        CMD_SLEW: slew_sel_q <= wdat_q;
        CMD_ILIM: ilim_q <= wdat_q;
        CMD_LL_CAL: llcal_q <= wdat_q;
        CMD_LL_SET: llset_q <= wdat_q;
        default: ;
      endcase
    end
  end

  always_comb begin
    unique case (cmd_q)
      CMD_DELAY: rd_data = delay_sel_q;
      CMD_SLEW: rd_data = slew_sel_q;
      CMD_ILIM: rd_data = ilim_q;
      CMD_LL_CAL: rd_data = llcal_q;
      CMD_LL_SET: rd_data = llset_q;
      CMD_STATUS: rd_data = {active_q[3:1], lat_busy_q, 4'(st_q)};
      default: rd_data = 8'h00;
    endcase
  end

  // scaling codes go straight to the analog trims
  assign scales = '{ilim: ilim_q[SCALE_MSB:0], ll_cal: llcal_q[SCALE_MSB:0],
                    ll_set: llset_q[SCALE_MSB:0]};

  // ------------------------------------------------------------
  // two-wire slave
  // ------------------------------------------------------------
  typedef enum logic [2:0] {I_IDLE, I_ADDR, I_CMD, I_WR, I_ACK, I_RD, I_RACK} rss_i2c_t;
  rss_i2c_t ist_q, nxt_q;
  logic [1:0] bus_p_q;
  logic [7:0] sh_q, byte_in;
  logic [2:0] bcnt_q;
  logic sda_oe_q;
  logic scl, sda, start, stop, rise, fall;

  assign scl = bus_s[1];
  assign sda = bus_s[0];
  assign start = scl & bus_p_q[1] & bus_p_q[0] & ~sda;
  assign stop = scl & bus_p_q[1] & ~bus_p_q[0] & sda;
  assign rise = scl & ~bus_p_q[1];
  assign fall = ~scl & bus_p_q[1];
  assign byte_in = {sh_q[6:0], sda};
  assign sda_out = 1'b0;
  assign sda_oe = sda_oe_q;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ist_q <= I_IDLE;
      nxt_q <= I_IDLE;
      bus_p_q <= 2'h0;
      sh_q <= 8'h00;
      bcnt_q <= 3'h0;
      sda_oe_q <= 1'b0;
      cmd_q <= 8'h00;
      wdat_q <= 8'h00;
      wr_q <= 1'b0;
    end else begin
      bus_p_q <= bus_s;
      wr_q <= 1'b0;
      if (stop) begin
        ist_q <= I_IDLE;
        sda_oe_q <= 1'b0;
      end else if (start) begin
        ist_q <= I_ADDR;
        bcnt_q <= 3'h0;
        sda_oe_q <= 1'b0;
      end else begin
        unique case (ist_q)
          I_IDLE: ;
          I_ADDR, I_CMD, I_WR: begin
            if (rise) begin
              sh_q <= byte_in;
              bcnt_q <= bcnt_q + 3'h1;
              if (bcnt_q == 3'h7) begin
                ist_q <= I_ACK;
                nxt_q <= I_WR;
                if (ist_q == I_ADDR) begin
                  nxt_q <= byte_in[0] ? I_RD : I_CMD;
                  if (byte_in[7:1] != DEV_ADDR) ist_q <= I_IDLE;
                end else if (ist_q == I_CMD) begin
                  cmd_q <= byte_in;
                end else begin
                  wdat_q <= byte_in;
                  wr_q <= 1'b1;
                end
              end
            end
          end
          I_ACK: begin
            if (fall && !sda_oe_q) begin
              sda_oe_q <= 1'b1;
            end else if (fall) begin
              ist_q <= nxt_q;
              bcnt_q <= 3'h0;
              sda_oe_q <= (nxt_q == I_RD) ? ~rd_data[7] : 1'b0;
              sh_q <= rd_data;
            end
          end
          I_RD: begin
            if (fall) sda_oe_q <= ~sh_q[7];
            if (rise) begin
              sh_q <= {sh_q[6:0], 1'b0};
              bcnt_q <= bcnt_q + 3'h1;
              if (bcnt_q == 3'h7) ist_q <= I_RACK;
            end
          end
          I_RACK: begin
            if (fall) sda_oe_q <= 1'b0;
            if (rise) begin
              ist_q <= sda ? I_IDLE : I_RD;
              sh_q <= rd_data;
              bcnt_q <= 3'h0;
            end
          end
          default: ist_q <= I_IDLE;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // startup sequence and shared delay timer
  // ------------------------------------------------------------
  logic [23:0] tmr_q, dly_cyc;
  logic [7:0] ref_q, tgt_q;
  logic tmr_done, go;

  // period is sampled only when an interval loads, so live writes wait for the next one
  assign dly_cyc = 24'((int'(delay_sel_q[SEL_MSB:0]) + 1) * DELAY_STEP_CYC);
  assign tmr_done = (tmr_q == 24'h000000);
  assign go = en_s & supply_ok_s;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      st_q <= S_IDLE;
      tmr_q <= 24'h000000;
      lat_busy_q <= 1'b0;
    end else if (!go) begin
      st_q <= S_IDLE;
      lat_busy_q <= 1'b0;
    end else begin
      unique case (st_q)
        S_IDLE: begin
          st_q <= S_FIRST;
          tmr_q <= dly_cyc - 24'h1;
        end
        S_FIRST: begin
          if (tmr_done) begin
            st_q <= S_DETECT;
            tmr_q <= 24'(DETECT_CYC - 1);
          end else tmr_q <= tmr_q - 24'h1;
        end
        S_DETECT: begin
          if (tmr_done) st_q <= S_BOOT_RAMP;
          else tmr_q <= tmr_q - 24'h1;
        end
        S_BOOT_RAMP: begin
          if (ref_q == BOOT_CODE) begin
            st_q <= S_BOOT_HOLD;
            tmr_q <= dly_cyc - 24'h1;
          end
        end
        S_BOOT_HOLD: begin
          if (tmr_done) st_q <= S_TGT_RAMP;
          else tmr_q <= tmr_q - 24'h1;
        end
        S_TGT_RAMP: begin
          if (ref_q == tgt_q) begin
            st_q <= S_PG_MASK;
            tmr_q <= 24'(PG_MASK_CYC - 1);
          end
        end
        S_PG_MASK: begin
          if (tmr_done) begin
            st_q <= S_PG_BLANK;
            tmr_q <= dly_cyc - 24'h1;
          end else tmr_q <= tmr_q - 24'h1;
        end
        S_PG_BLANK: begin
          if (tmr_done) st_q <= S_RUN;
          else tmr_q <= tmr_q - 24'h1;
        end
        S_RUN: begin
          // a trip seen earlier in startup is only timed from here on
          if (!trip_s) lat_busy_q <= 1'b0;
          else if (!lat_busy_q) begin
            lat_busy_q <= 1'b1;
            tmr_q <= 24'(LATCH_MULT * int'(dly_cyc)) - 24'h1;
          end else if (tmr_done) st_q <= S_OFF;
          else tmr_q <= tmr_q - 24'h1;
        end
        S_OFF: ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // soft-start reference ramp
  // ------------------------------------------------------------
  logic [15:0] stp_q, stp_len_q;
  logic [7:0] aim;
  logic ramp_load, ramping;

  function automatic logic [15:0] ramp_cyc(input logic [2:0] c);
    int r;
    r = 1;
    for (int k = 0; k < 8; k++) begin
      if (c == 3'(k)) r = RAMP_NUM / (SLEW_BASE_MV_MS + SLEW_INC_MV_MS * k);
    end
    if (r < 1) r = 1;
    return 16'(r);
  endfunction : ramp_cyc

  assign ramp_load = tmr_done && (st_q == S_DETECT || st_q == S_BOOT_HOLD);
  assign ramping = (st_q == S_BOOT_RAMP) || (st_q == S_TGT_RAMP);
  assign aim = (st_q == S_BOOT_RAMP) ? BOOT_CODE : tgt_q;

  always_ff @(posedge clk_sys) begin
    if (!nrst || !go || st_q == S_IDLE) begin
      ref_q <= 8'h00;
      tgt_q <= 8'h00;
      stp_q <= 16'h0000;
      stp_len_q <= 16'h0001;
    end else if (ramp_load) begin
      stp_len_q <= ramp_cyc(slew_sel_q[SEL_MSB:0]);
      stp_q <= ramp_cyc(slew_sel_q[SEL_MSB:0]) - 16'h1;
      if (st_q == S_BOOT_HOLD) tgt_q <= tv_s;
    end else if (ramping && ref_q != aim) begin
      if (stp_q == 16'h0000) begin
        ref_q <= (ref_q < aim) ? ref_q + 8'h01 : ref_q - 8'h01;
        stp_q <= stp_len_q - 16'h1;
      end else stp_q <= stp_q - 16'h1;
    end
  end

  // ------------------------------------------------------------
  // phase detection, rotation and outputs
  // ------------------------------------------------------------
  logic [1:0] slot_q, slot_d;
  logic [3:0] tick_q, pin_o_q, pin_oe_q;
  logic sink_q, switching, pg_q, trip_q;

  assign switching = ramping || (st_q inside {S_BOOT_HOLD, S_PG_MASK, S_PG_BLANK, S_RUN});

  always_comb begin
    slot_d = slot_q;
    for (int k = 3; k >= 1; k--) begin
      if (active_q[2'(int'(slot_q) + k)]) slot_d = 2'(int'(slot_q) + k);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      active_q <= 4'hF;
      slot_q <= 2'h0;
      tick_q <= 4'h0;
      pin_o_q <= 4'h0;
      pin_oe_q <= 4'h1;
      sink_q <= 1'b0;
    end else begin
      // tied-high pins drop out of rotation; output one always switches
      if (st_q == S_DETECT && tmr_done) active_q <= {~pin_s, 1'b1};
      slot_q <= switching ? slot_d : 2'h0;
      tick_q <= switching ? (4'h1 << slot_d) : 4'h0;
      // each pin follows its own demand, so overlap and long duty pass through
      pin_o_q <= (switching && st_q != S_OFF) ? (pwm_req & active_q) : 4'h0;
      pin_oe_q <= switching ? active_q : 4'h1;
      sink_q <= go && (st_q inside {S_IDLE, S_FIRST, S_DETECT});
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      pg_q <= 1'b0;
      trip_q <= 1'b0;
    end else begin
      pg_q <= (st_q == S_RUN);
      trip_q <= trip_s;
    end
  end

  assign phase_pins = '{drive: pin_o_q, enable: pin_oe_q};
  assign phase_sink_en = sink_q;
  assign phase_tick = tick_q;
  assign ref_code = ref_q;
  assign power_good = pg_q;
  assign limit_trip = trip_q;
  assign latched_off = (st_q == S_OFF);

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  a_first_delay_gate: assert property ((st_q == S_FIRST && $past(st_q) == S_IDLE) |-> $past(go))
    else $error("first delay started without enable and supply");
  a_delay_period_load: assert property ((st_q == S_FIRST && $past(st_q) == S_IDLE)
      |-> tmr_q == 24'((int'($past(delay_sel_q[2:0])) + 1) * DELAY_STEP_CYC - 1))
    else $error("delay timer loaded with wrong period");
  a_latch_period_load: assert property ((lat_busy_q && !$past(lat_busy_q))
      |-> tmr_q == 24'(4 * (int'($past(delay_sel_q[2:0])) + 1) * DELAY_STEP_CYC - 1))
    else $error("latchoff period is not four delay periods");
  a_latch_after_blank: assert property (lat_busy_q |-> st_q inside {S_RUN, S_OFF})
    else $error("latchoff timing outside normal run");
  a_ramp_single_step: assert property ((ref_q != $past(ref_q) && st_q != S_IDLE)
      |-> (ref_q == $past(ref_q) + 8'h01 || ref_q == $past(ref_q) - 8'h01))
    else $error("reference moved by more than one step");
  a_boot_hold_level: assert property ((st_q == S_BOOT_RAMP ##1 st_q == S_BOOT_HOLD)
      |-> ref_q == BOOT_CODE)
    else $error("boot hold started away from boot level");
  a_target_reached: assert property ((st_q == S_TGT_RAMP ##1 st_q == S_PG_MASK)
      |-> ref_q == tgt_q)
    else $error("second ramp ended off target");
  a_detect_out_low: assert property ((st_q == S_DETECT && $past(st_q) == S_DETECT)
      |-> pin_oe_q[0] && !pin_o_q[0])
    else $error("output one not held low during detection");
  a_unused_hiz: assert property (st_q == S_RUN ##1 st_q == S_RUN
      |-> (pin_oe_q & ~active_q) == 4'h0 && (tick_q & ~active_q) == 4'h0)
    else $error("unused phase driven or ticked");
  a_blank_then_good: assert property ((st_q == S_PG_BLANK ##1 st_q == S_RUN) |-> ##1 pg_q)
    else $error("power good not raised after blanking");
endmodule : rss_sequencer

/* File: verilog/rss_pkg.sv */
// Operation
// - first delay starts only with enable high and undervoltage lockout cleared
// - one shared delay timer times first, hold and blanking intervals, default 2 ms
// - delay code bits 2:0 of 0xD4 pick 0.5 to 4 ms, default 011
// - overcurrent latchoff lasts four programmed delay periods
// - latchoff timing begins only after power-good blanking has completed
// - after first delay and detection, reference rises in 6.25 mV steps to 1.1 V
// - boot level starts the hold delay; second ramp begins when it expires
// - second ramp moves reference up or down to sampled target code in steps
// - slew code bits 2:0 of 0xD5 pick 0.1 to 1.5 V/ms, default 010
// - after second ramp and masking, a third timer run blanks power-good
// - first six detection cycles hold output one low and sample the others
// - board ties unused upper outputs high; device defaults to four phases
// - outputs sampled low switch normally; outputs sampled high go high-impedance
// - per-phase rate is master clock divided by the number of active phases
// - each phase output is independent; overlap and near full duty allowed
// - flag a current-limit trip when sense current exceeds its reference
// - bits 4:0 of 0xE2 scale current limit, default code 10000
// - load-line scaling set through commands 0xDE and 0xDF
package rss_pkg;

  // ------------------------------------------------------------
  // command codes
  // ------------------------------------------------------------
  localparam logic [7:0] CMD_DELAY = 8'hD4;
  localparam logic [7:0] CMD_SLEW = 8'hD5;
  localparam logic [7:0] CMD_LL_CAL = 8'hDE;
  localparam logic [7:0] CMD_LL_SET = 8'hDF;
  localparam logic [7:0] CMD_ILIM = 8'hE2;
  localparam logic [7:0] CMD_STATUS = 8'hEF;

  // ------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------
  localparam int SEL_MSB = 2;
  localparam int SCALE_MSB = 4;
  localparam logic [7:0] DELAY_RST = 8'h03;
  localparam logic [7:0] SLEW_RST = 8'h02;
  localparam logic [7:0] ILIM_RST = 8'h10;
  localparam logic [7:0] LL_RST = 8'h10;
  localparam logic [6:0] DEV_ADDR_RST = 7'h20;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int DELAY_STEP_US = 500;
  localparam int DELAY_STEP_CYC = DELAY_STEP_US * 1000 / CLK_PERIOD_NS;
  localparam int LATCH_MULT = 4;
  localparam int DETECT_CYC = 6;
  localparam int PG_MASK_US = 1;
  localparam int PG_MASK_CYC = PG_MASK_US * 1000 / CLK_PERIOD_NS;
  localparam int STEP_UV = 6250;
  localparam int BOOT_MV = 1100;
  localparam logic [7:0] BOOT_CODE = 8'(BOOT_MV * 1000 / STEP_UV);
  localparam int SLEW_BASE_MV_MS = 100;
  localparam int SLEW_INC_MV_MS = 200;
  localparam int RAMP_NUM = STEP_UV * 1000 / CLK_PERIOD_NS;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE, S_FIRST, S_DETECT, S_BOOT_RAMP, S_BOOT_HOLD, S_TGT_RAMP,
    S_PG_MASK, S_PG_BLANK, S_RUN, S_OFF
  } rss_seq_t;

  typedef struct packed {
    logic [3:0] drive;
    logic [3:0] enable;
  } rss_pins_t;

  typedef struct packed {
    logic [4:0] ilim;
    logic [4:0] ll_cal;
    logic [4:0] ll_set;
  } rss_scale_t;

endpackage : rss_pkg

/* File: verilog/rss_sync.sv */
`timescale 1ns/100ps
module rss_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // a bit only changes once the last two stages agree, filtering single-cycle glitches
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      q <= '0;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      q <= (s3_q & ~(s2_q ^ s3_q)) | (q & (s2_q ^ s3_q));
    end
  end
endmodule : rss_sync

/* File: test/rss_board.sv */
`timescale 1ns/100ps
module rss_board
  import rss_pkg::*;
(
  input wire logic clk_sys,
  input rss_pkg::rss_pins_t phase_pins,
  input wire logic phase_sink_en,
  input wire logic [3:1] tie_hi,
  input wire logic sda_host,
  input wire logic sda_oe,
  output logic [3:1] phase_sense,
  output logic sda_line
);
  logic [3:1] last_q;

  // ------------------------------------------------------------
  // board wiring
  // ------------------------------------------------------------
  // data line has a pull-up, so it is low only when someone sinks it
  assign sda_line = sda_host & ~sda_oe;

  // a floating pin shows the inverse of its last level, so a missing sink toggles every cycle instead of reading steadily low
  always_comb begin
    for (int i = 1; i < 4; i++) begin
      if (tie_hi[i]) phase_sense[i] = 1'b1;
      else if (phase_pins.enable[i]) phase_sense[i] = phase_pins.drive[i];
      else if (phase_sink_en) phase_sense[i] = 1'b0;
      else phase_sense[i] = ~last_q[i];
    end
  end

  always_ff @(posedge clk_sys) last_q <= phase_sense;
endmodule : rss_board

/* File: test/regulator_startup_sequencer_tb_top.sv */
`timescale 1ns/100ps
module regulator_startup_sequencer_tb_top;
  import rss_pkg::*;
  localparam int DSTEP = 20;
  localparam int PGM = 100;
  localparam int HB = 10;
  localparam logic [6:0] ADDR = 7'h20;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic en_pin = 1'b0;
  logic lockout = 1'b1;
  logic limit_over = 1'b0;
  logic [7:0] tgt = 8'hC8;
  logic [3:0] pwm_req = 4'hF;
  logic scl = 1'b1;
  logic sda_h = 1'b1;
  logic [3:1] tie_hi = 3'h0;
  logic [3:1] phase_sense;
  logic sda_line, sda_out, sda_oe, phase_sink_en, power_good, limit_trip, latched_off;
  rss_pins_t phase_pins;
  logic [3:0] phase_tick;
  logic [7:0] ref_code;
  logic [7:0] ref_prev = 8'h00;
  rss_scale_t scales;
  int mismatches = 0;
  int compares = 0;

  always #5 clk_sys = ~clk_sys;

  rss_sequencer #(.DELAY_STEP_CYC(DSTEP), .RAMP_NUM(1500), .PG_MASK_CYC(PGM)) dut (
    .clk_sys(clk_sys), .nrst(nrst), .en_pin(en_pin), .supply_undervoltage_lockout(lockout),
    .limit_over(limit_over), .target_voltage_code(tgt), .pwm_req(pwm_req),
    .phase_sense(phase_sense), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .phase_pins(phase_pins), .phase_sink_en(phase_sink_en),
    .phase_tick(phase_tick), .ref_code(ref_code), .power_good(power_good),
    .limit_trip(limit_trip), .latched_off(latched_off), .scales(scales));

  rss_board board (.clk_sys(clk_sys), .phase_pins(phase_pins), .phase_sink_en(phase_sink_en),
    .tie_hi(tie_hi), .sda_host(sda_h), .sda_oe(sda_oe), .phase_sense(phase_sense),
    .sda_line(sda_line));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic end_sim();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_cnt(input int got, input int lo, input int hi);
    compares++;
    if (got < lo || got > hi) begin
      mismatches++;
      $display("Error at %0t: count %0h expected %0h..%0h", $time, got, lo, hi);
    end
  endtask : chk_cnt

  function automatic logic [7:0] probe(input int sel);
    case (sel)
      0: return ref_code;
      1: return {7'h00, power_good};
      2: return {7'h00, latched_off};
      3: return {4'h0, phase_pins.enable};
      default: return {7'h00, limit_trip};
    endcase
  endfunction : probe

  task automatic wait_on(input int sel, input logic [7:0] v, input int lim, output int n);
    n = 0;
    while (probe(sel) !== v && n < lim) begin
      tick(1);
      n++;
    end
    if (n >= lim) begin
      mismatches++;
      $display("Error at %0t: wait got %0h expected %0h", $time, probe(sel), v);
      end_sim();
    end
  endtask : wait_on

  task automatic tick_cnt(input int len, output int k);
    k = 0;
    for (int i = 0; i < len; i++) begin
      tick(1);
      k += phase_tick[0];
    end
  endtask : tick_cnt

  // every ramp move between nonzero codes is one step
  always @(negedge clk_sys) begin
    if (ref_code !== ref_prev && ref_code !== 8'h00 && ref_prev !== 8'h00)
      chk_val(ref_code > ref_prev ? ref_code - ref_prev : ref_prev - ref_code, 1);
    ref_prev <= ref_code;
  end

  // ------------------------------------------------------------
  // serial host
  // ------------------------------------------------------------
  task automatic bit_io(input logic b, output logic r);
    sda_h = b;
    tick(HB);
    scl = 1'b1;
    tick(HB);
    r = sda_line;
    scl = 1'b0;
    tick(HB);
  endtask : bit_io

  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(1'b1, ack);
  endtask : xfer

  task automatic start_c();
    sda_h = 1'b1;
    tick(HB);
    scl = 1'b1;
    tick(HB);
    sda_h = 1'b0;
    tick(HB);
    scl = 1'b0;
    tick(HB);
  endtask : start_c

  task automatic stop_c();
    sda_h = 1'b0;
    tick(HB);
    scl = 1'b1;
    tick(HB);
    sda_h = 1'b1;
    tick(HB);
  endtask : stop_c

  task automatic reg_wr(input logic [7:0] cmd, input logic [7:0] d);
    logic [7:0] rx;
    logic a0, a1, a2;
    start_c();
    xfer({ADDR, 1'b0}, rx, a0);
    xfer(cmd, rx, a1);
    xfer(d, rx, a2);
    stop_c();
    chk_val({a0, a1, a2}, 3'b000);
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] cmd, output logic [7:0] d);
    logic [7:0] rx;
    logic a0, a1, a2, a3;
    start_c();
    xfer({ADDR, 1'b0}, rx, a0);
    xfer(cmd, rx, a1);
    start_c();
    xfer({ADDR, 1'b1}, rx, a2);
    xfer(8'hFF, d, a3);
    stop_c();
    chk_val({a0, a1, a2}, 3'b000);
  endtask : reg_rd

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic sc_defaults();
    logic [7:0] d;
    reg_rd(CMD_DELAY, d);
    chk_val(d, 8'h03);
    reg_rd(CMD_SLEW, d);
    chk_val(d, 8'h02);
    reg_rd(CMD_ILIM, d);
    chk_val(d, 8'h10);
    reg_rd(8'h00, d);
    chk_val(d, 8'h00);
    chk_val(scales, {5'h10, 5'h10, 5'h10});
    chk_val(sda_out, 1'b0);
  endtask : sc_defaults

  task automatic sc_startup();
    int n;
    en_pin = 1'b1;
    tick(200);
    chk_val({phase_pins.enable, ref_code}, 12'h100);
    lockout = 1'b0;
    wait_on(3, 8'h0F, 400, n);
    chk_cnt(n, 4 * DSTEP + 6, 4 * DSTEP + 12);
    wait_on(0, 8'h02, 50, n);
    wait_on(0, 8'h03, 50, n);
    chk_cnt(n, 3, 3);
    wait_on(0, 8'hB0, 1000, n);
    wait_on(0, 8'hB1, 200, n);
    chk_cnt(n, 4 * DSTEP, 4 * DSTEP + 8);
    wait_on(0, 8'hC8, 200, n);
    wait_on(1, 8'h01, 400, n);
    chk_cnt(n, PGM + 4 * DSTEP, PGM + 4 * DSTEP + 8);
    pwm_req = 4'b1011;
    tick(2);
    chk_val(phase_pins, {4'b1011, 4'hF});
    tick_cnt(40, n);
    chk_cnt(n, 10, 10);
    limit_over = 1'b1;
    wait_on(4, 8'h01, 8, n);
    tick(200);
    limit_over = 1'b0;
    tick(10);
    chk_val(latched_off, 1'b0);
    limit_over = 1'b1;
    wait_on(2, 8'h01, 400, n);
    chk_cnt(n, 16 * DSTEP, 16 * DSTEP + 10);
    en_pin = 1'b0;
    limit_over = 1'b0;
    tick(8);
    chk_val({latched_off, power_good, ref_code}, 10'h000);
  endtask : sc_startup

  task automatic sc_program();
    int n;
    logic [7:0] d;
    reg_wr(CMD_DELAY, 8'h00);
    reg_wr(CMD_SLEW, 8'h00);
    reg_wr(CMD_ILIM, 8'h1F);
    reg_wr(CMD_LL_CAL, 8'h05);
    reg_wr(CMD_LL_SET, 8'h1A);
    reg_rd(CMD_ILIM, d);
    chk_val(d, 8'h1F);
    chk_val(scales, {5'h1F, 5'h05, 5'h1A});
    tie_hi = 3'b110;
    tgt = 8'h64;
    limit_over = 1'b1;
    en_pin = 1'b1;
    wait_on(3, 8'h03, 400, n);
    chk_cnt(n, DSTEP + 6, DSTEP + 12);
    tick(1);
    chk_val(phase_pins, {4'b0011, 4'b0011});
    tick_cnt(20, n);
    chk_cnt(n, 10, 10);
    wait_on(0, 8'h02, 100, n);
    wait_on(0, 8'h03, 100, n);
    chk_cnt(n, 15, 15);
    reg_wr(CMD_SLEW, 8'h07);
    wait_on(0, ref_code + 8'h01, 30, n);
    wait_on(0, ref_code + 8'h01, 30, n);
    chk_cnt(n, 15, 15);
    wait_on(0, 8'hB0, 3000, n);
    wait_on(0, 8'h64, 400, n);
    wait_on(1, 8'h01, 400, n);
    wait_on(2, 8'h01, 200, n);
    chk_cnt(n, 4 * DSTEP, 4 * DSTEP + 10);
    reg_rd(CMD_STATUS, d);
    chk_val(d, 8'h39);
    en_pin = 1'b0;
    limit_over = 1'b0;
    tick(8);
    en_pin = 1'b1;
    wait_on(0, 8'h05, 200, n);
    wait_on(0, 8'h06, 10, n);
    chk_cnt(n, 1, 1);
    lockout = 1'b1;
    tick(8);
    chk_val(ref_code, 8'h00);
  endtask : sc_program

  initial begin
    tick(16);
    nrst = 1'b1;
    tick(5);
    sc_defaults();
    sc_startup();
    sc_program();
    end_sim();
  end
endmodule : regulator_startup_sequencer_tb_top
